/* File: rtl/tsc_defs.svh */
// Offsets, field positions, codes and counts of the time-slot switch
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH
`define TSC_A_MADDR 8'h00
`define TSC_A_MDATA 8'h04
`define TSC_A_MCMD 8'h08
`define TSC_A_MODE 8'h0C
`define TSC_A_TOP_INTERRUPT_STATUS 8'h10
`define TSC_A_TOP_INTERRUPT_STATUS_SW 8'h14
`define TSC_A_CMD 8'h18
`define TSC_A_STAT 8'h1C
`define TSC_A_STAT_SW 8'h20
`define TSC_A_INDICATION_CHANGE_FIFO 8'h24
`define TSC_A_ARB_EN 8'h28
`define TSC_CMD_WR_DATA 8'h48
`define TSC_CMD_RD_DATA 8'hC8
`define TSC_CMD_WR_TRI 8'h68
`define TSC_CMD_WR_CODE 4'h7
`define TSC_CODE_SWITCH 4'h1
`define TSC_CODE_MON_EVEN 4'h8
`define TSC_CODE_CI_EVEN 4'hA
`define TSC_CODE_CI_ODD 4'hB
`define TSC_COMMAND_REG_FIFO_RST 8'h10
`define TSC_MODE_NORMAL_SUB 8'hCE
`define TSC_MODE_NORMAL_ALL 8'hEE
`define TSC_MB_LIVE 7
`define TSC_MB_NORMAL 6
`define TSC_MB_TRUNK 5
`define TSC_MB_OPEN_DRAIN 3
`define TSC_MB_SUB_EN 2
`define TSC_STAT_OK 8'h25
`define TSC_TOP_INTERRUPT_STATUS_STARTUP 8'h48
`define TSC_ARB_MASK 8'hEF
`define TSC_IDLE_BYTE 8'hFF
`define TSC_SPURIOUS_ENTRY 8'h00
`define TSC_TRI_LAST 8'h1F
`define TSC_CM_LAST 8'hFF
`define TSC_FRAME_LAST 8'hFF
`endif

/* File: rtl/tsc_pkg.sv */
// Types and address helpers of the time-slot switch
package tsc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_TRI, ST_FILL} tsc_mstate_t;

	// Slot number held in a memory address or a switching target
	function automatic logic [4:0] slot_of(input logic [7:0] a);
		slot_of = {a[6:5], a[4:3], a[0]};
	endfunction : slot_of

	// Memory address of port 0 for a direction and slot
	function automatic logic [7:0] addr_of(input logic up, input logic [4:0] s);
		addr_of = {up, s[4:3], s[2:1], 2'b00, s[0]};
	endfunction : addr_of

	// Indication code in the middle of a signalling byte
	function automatic logic [3:0] ci_of(input logic [7:0] d);
		ci_of = d[5:2];
	endfunction : ci_of
endpackage : tsc_pkg

/* File: rtl/tsc_slot_if.sv */
// Frame position and sampled link bits passed from the timer to the core
`timescale 1ns/1ps
interface tsc_slot_if;
	logic [4:0] slot;
	logic [2:0] bit_idx;
	logic rx_stb;
	logic tx_stb;
	logic sub_bit;
	logic trunk_bit;
	logic synced;
	modport timer(output slot, bit_idx, rx_stb, tx_stb, sub_bit, trunk_bit, synced);
	modport core(input slot, bit_idx, rx_stb, tx_stb, sub_bit, trunk_bit, synced);
endinterface : tsc_slot_if

/* File: rtl/tsc_frame_timer.sv */
// Link clock sampling, frame alignment and bit/slot counting
`timescale 1ns/1ps
`include "tsc_defs.svh"
module tsc_frame_timer (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic link_clk,
	input wire logic frame_sync,
	input wire logic sub_rx,
	input wire logic trunk_rx,
	tsc_slot_if.timer tif
);
	logic [3:0] s1_r;
	logic [3:0] s2_r;
	logic clk_d_r;
	logic [7:0] cnt_r;
	logic rx_stb_r;
	logic tx_stb_r;
	logic sub_r;
	logic trunk_r;
	logic synced_r;

	// Edges of the synchronised link clock
	wire logic rise = s2_r[0] & ~clk_d_r;
	wire logic fall = ~s2_r[0] & clk_d_r;
	wire logic fs = s2_r[1];

	// Two-stage synchronisers for all pins
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s1_r <= 4'h0;
			s2_r <= 4'h0;
			clk_d_r <= 1'b0;
		end else begin
			s1_r <= {trunk_rx, sub_rx, frame_sync, link_clk};
			s2_r <= s1_r;
			clk_d_r <= s2_r[0];
		end
	end

	// Bit counter; frame sync marks bit 0 of slot 0
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 8'h00;
			synced_r <= 1'b0;
		end else if (rise) begin
			cnt_r <= fs ? 8'h00 : cnt_r + 8'h01;
			if (fs)
				synced_r <= (cnt_r == `TSC_FRAME_LAST);
			else if (cnt_r == `TSC_FRAME_LAST)
				synced_r <= 1'b0;
		end
	end

	// Receive strobe and sampled bits registered on the same cycle as the counter update; transmit strobe on the fall
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_stb_r <= 1'b0;
			tx_stb_r <= 1'b0;
			sub_r <= 1'b1;
			trunk_r <= 1'b1;
		end else begin
			rx_stb_r <= rise;
			tx_stb_r <= fall;
			if (rise) begin
				sub_r <= s2_r[2];
				trunk_r <= s2_r[3];
			end
		end
	end

	assign tif.slot = cnt_r[7:3];
	assign tif.bit_idx = cnt_r[2:0];
	assign tif.rx_stb = rx_stb_r;
	assign tif.tx_stb = tx_stb_r;
	assign tif.sub_bit = sub_r;
	assign tif.trunk_bit = trunk_r;
	assign tif.synced = synced_r;
endmodule : tsc_frame_timer

/* File: rtl/tsc_ci_fifo.sv */
// Indication-change FIFO, 16 entries of 8 bits
`timescale 1ns/1ps
module tsc_ci_fifo (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic push,
	input wire logic [7:0] push_data,
	input wire logic pop,
	input wire logic clear,
	output logic [7:0] head,
	output logic not_empty
);
	logic [7:0] mem [16];
	logic [3:0] wp_r;
	logic [3:0] rp_r;
	logic [4:0] cnt_r;

	// Push while full is dropped; a push in the clearing cycle survives
	wire logic full = cnt_r[4];
	wire logic do_push = push & (~full | clear);
	wire logic do_pop = pop & not_empty & ~clear;
	wire logic [3:0] wa = clear ? 4'h0 : wp_r;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wp_r <= 4'h0;
			rp_r <= 4'h0;
			cnt_r <= 5'h00;
		end else if (clear) begin
			rp_r <= 4'h0;
			wp_r <= {3'h0, do_push};
			cnt_r <= {4'h0, do_push};
		end else begin
			wp_r <= wp_r + {3'h0, do_push};
			rp_r <= rp_r + {3'h0, do_pop};
			cnt_r <= cnt_r + {4'h0, do_push} - {4'h0, do_pop};
		end
	end

	// Entry storage
	always_ff @(posedge mclk) begin
		if (do_push)
			mem[wa] <= push_data;
	end

	assign head = mem[rp_r];
	assign not_empty = (cnt_r != 5'h00);
endmodule : tsc_ci_fifo

/* File: rtl/tsc_switch_core.sv */
// Time-slot switch with control memory, indication monitor and AHB-Lite registers
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "tsc_defs.svh"
module tsc_switch_core import tsc_pkg::*; (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic link_clk,
	input wire logic frame_sync,
	input wire logic sub_rx,
	output logic sub_tx_o,
	output logic sub_tx_oe,
	input wire logic trunk_rx,
	output logic trunk_tx_o,
	output logic trunk_tx_oe
);
	tsc_slot_if tif ();

	// Control memory, tristate memory and trunk buffers; no reset
	logic [7:0] cm_data [256];
	logic [3:0] cm_code [256];
	logic [3:0] tri_mem [32];
	logic [7:0] trunk_tx_buf [32];
	logic [7:0] trunk_rx_buf [32];

	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] hrdata_r;
	logic [7:0] maddr_r;
	logic [7:0] mdata_r;
	logic [7:0] mcmd_r;
	logic [7:0] mode_r;
	logic [7:0] arb_en_r;
	logic sync_chg_r;
	logic synced_d_r;
	logic sub_en_d_r;
	logic busy_r;
	tsc_mstate_t st_r;
	tsc_mstate_t st_nxt;
	logic [7:0] idx_r;
	logic [7:0] idx_nxt;
	logic [7:0] up_sh_r;
	logic [7:0] tr_sh_r;
	logic sub_o_r;
	logic sub_oe_r;
	logic tr_o_r;
	logic tr_oe_r;
	logic [7:0] fifo_head;
	logic fifo_ne;

	tsc_frame_timer u_timer (
		.mclk(mclk),
		.reset_n(reset_n),
		.link_clk(link_clk),
		.frame_sync(frame_sync),
		.sub_rx(sub_rx),
		.trunk_rx(trunk_rx),
		.tif(tif)
	);

	// Bus address phase decode
	wire logic acc = hsel & htrans[1] & hready;
	wire logic a_hit = (haddr[31:8] == 24'h0) & (haddr[1:0] == 2'b00);
	wire logic [7:0] a_off = a_hit ? haddr[7:0] : 8'hFF;
	wire logic rd_acc = acc & ~hwrite;
	wire logic rd_fifo = rd_acc & (a_off == `TSC_A_INDICATION_CHANGE_FIFO);
	wire logic rd_top_interrupt_status = rd_acc & (a_off == `TSC_A_TOP_INTERRUPT_STATUS);

	// Data phase write strobes
	wire logic [7:0] wd = hwdata[7:0];
	wire logic wr_maddr = wr_pend_r & (wr_addr_r == `TSC_A_MADDR);
	wire logic wr_mdata = wr_pend_r & (wr_addr_r == `TSC_A_MDATA);
	wire logic wr_mcmd = wr_pend_r & (wr_addr_r == `TSC_A_MCMD);
	wire logic wr_mode = wr_pend_r & (wr_addr_r == `TSC_A_MODE);
	wire logic wr_arb = wr_pend_r & (wr_addr_r == `TSC_A_ARB_EN);
	wire logic wr_fifo_rst = wr_pend_r & (wr_addr_r == `TSC_A_CMD) & (wd == `TSC_COMMAND_REG_FIFO_RST);

	// Operating modes
	wire logic cm_reset_mode = ~mode_r[`TSC_MB_LIVE];
	wire logic run_mode = mode_r[`TSC_MB_LIVE] & mode_r[`TSC_MB_NORMAL];
	wire logic sub_en = run_mode & mode_r[`TSC_MB_SUB_EN];
	wire logic trunk_en = run_mode & mode_r[`TSC_MB_TRUNK];
	wire logic startup = sub_en & ~sub_en_d_r;

	// Upstream slot end: monitoring and switching
	wire logic slot_end = tif.rx_stb & (tif.bit_idx == 3'h7);
	wire logic [7:0] ubyte = {up_sh_r[6:0], tif.sub_bit};
	wire logic [7:0] tbyte = {tr_sh_r[6:0], tif.trunk_bit};
	wire logic [7:0] up_addr = addr_of(1'b1, tif.slot);
	wire logic [3:0] up_code = cm_code[up_addr];
	wire logic [7:0] up_data = cm_data[up_addr];
	wire logic ci_diff = ci_of(ubyte) != ci_of(up_data);
	wire logic hw_we = slot_end & run_mode & (up_code == `TSC_CODE_MON_EVEN) & ci_diff;
	wire logic to_trunk = slot_end & run_mode & (up_code == `TSC_CODE_SWITCH);

	// Downstream byte for the current slot
	wire logic [7:0] dn_addr = addr_of(1'b0, tif.slot);
	wire logic [3:0] dn_code = cm_code[dn_addr];
	wire logic [7:0] dn_data = cm_data[dn_addr];
	wire logic dn_ci = (dn_code == `TSC_CODE_CI_EVEN) | (dn_code == `TSC_CODE_CI_ODD);
	wire logic arb_hit = (dn_code == `TSC_CODE_CI_EVEN) & arb_en_r[tif.slot[4:2]];
	wire logic [7:0] ci_byte = arb_hit ? (dn_data & `TSC_ARB_MASK) : dn_data;
	wire logic [7:0] sw_byte = trunk_rx_buf[slot_of(dn_data)];
	wire logic [7:0] dn_byte = (dn_code == `TSC_CODE_SWITCH) ? sw_byte :
		(dn_ci ? ci_byte : `TSC_IDLE_BYTE);
	wire logic [2:0] tx_bit = 3'h7 - tif.bit_idx;
	wire logic dn_bit = dn_byte[tx_bit];
	wire logic [7:0] tr_byte = trunk_tx_buf[tif.slot];
	// A cleared tristate bit keeps its trunk slot in high impedance
	wire logic tri_cur = ~tri_mem[tif.slot][0];

	// Host memory access decode
	wire logic host_exec = (st_r == ST_EXEC) & ~hw_we;
	wire logic cmd_code_wr = (mcmd_r[7:4] == `TSC_CMD_WR_CODE);
	wire logic [3:0] cmd_code = mcmd_r[3:0];
	wire logic host_cw = host_exec & cmd_code_wr & ~cm_reset_mode;
	wire logic host_dw = host_cw | (host_exec & (mcmd_r == `TSC_CMD_WR_DATA));
	wire logic fill_we = (st_r == ST_FILL);
	wire logic cm_we_d = hw_we | host_dw | fill_we;
	wire logic cm_we_c = host_cw | fill_we;
	wire logic [7:0] cm_wa = hw_we ? up_addr : (fill_we ? idx_r : maddr_r);
	wire logic [7:0] cm_wd = hw_we ? ubyte : mdata_r;
	wire logic [7:0] host_rd = cm_data[maddr_r];
	wire logic [3:0] host_code = cm_code[maddr_r];

	// Readable status words
	wire logic [7:0] stat_val = {2'b00, run_mode, 2'b00, tif.synced, 1'b0, tif.synced};
	wire logic [7:0] top_interrupt_status_val = {1'b0, fifo_ne, 2'b00, sync_chg_r, 3'b000};
	wire logic [7:0] top_interrupt_status_sw = {1'b0, fifo_ne, 6'h00};
	wire logic [7:0] stat_sw = {3'b000, busy_r, 4'h0};
	wire logic [7:0] rd_val = (a_off == `TSC_A_MADDR) ? maddr_r :
		(a_off == `TSC_A_MDATA) ? mdata_r :
		(a_off == `TSC_A_MCMD) ? mcmd_r :
		(a_off == `TSC_A_MODE) ? mode_r :
		(a_off == `TSC_A_TOP_INTERRUPT_STATUS) ? top_interrupt_status_val :
		(a_off == `TSC_A_TOP_INTERRUPT_STATUS_SW) ? top_interrupt_status_sw :
		(a_off == `TSC_A_STAT) ? stat_val :
		(a_off == `TSC_A_STAT_SW) ? stat_sw :
		(a_off == `TSC_A_INDICATION_CHANGE_FIFO) ? fifo_head :
		(a_off == `TSC_A_ARB_EN) ? arb_en_r : 8'h00;

	tsc_ci_fifo u_fifo (
		.mclk(mclk),
		.reset_n(reset_n),
		.push(hw_we | startup),
		.push_data(startup ? `TSC_SPURIOUS_ENTRY : up_addr),
		.pop(rd_fifo),
		.clear(wr_fifo_rst),
		.head(fifo_head),
		.not_empty(fifo_ne)
	);

	// Bus pipeline: zero wait states, always OKAY
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end else begin
			wr_pend_r <= acc & hwrite & (hsize == 3'b010);
			wr_addr_r <= a_off;
			hrdata_r <= rd_acc ? {24'h00_0000, rd_val} : 32'h0000_0000;
		end
	end

	// Host registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			maddr_r <= 8'h00;
			mcmd_r <= 8'h00;
			mode_r <= 8'h00;
			arb_en_r <= 8'h00;
		end else begin
			if (wr_maddr) maddr_r <= wd;
			if (wr_mcmd) mcmd_r <= wd;
			if (wr_mode) mode_r <= wd;
			if (wr_arb) arb_en_r <= wd;
		end
	end

	// Data register: host write or memory read result
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			mdata_r <= 8'h00;
		else if (wr_mdata)
			mdata_r <= wd;
		else if (host_exec & (mcmd_r == `TSC_CMD_RD_DATA))
			mdata_r <= host_rd;
	end

	// Sticky sync change; a set in the reading cycle wins
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sync_chg_r <= 1'b0;
			synced_d_r <= 1'b0;
			sub_en_d_r <= 1'b0;
		end else begin
			synced_d_r <= tif.synced;
			sub_en_d_r <= sub_en;
			if (startup | (tif.synced != synced_d_r))
				sync_chg_r <= 1'b1;
			else if (rd_top_interrupt_status)
				sync_chg_r <= 1'b0;
		end
	end

	// Memory access sequencer; hardware updates take precedence
	always_comb begin
		st_nxt = st_r;
		idx_nxt = idx_r;
		case (st_r)
			ST_IDLE: begin
				idx_nxt = 8'h00;
				if (wr_mcmd) st_nxt = ST_EXEC;
			end
			ST_EXEC: begin
				if (!hw_we) begin
					if (mcmd_r == `TSC_CMD_WR_TRI) st_nxt = ST_TRI;
					else if (cmd_code_wr & cm_reset_mode) st_nxt = ST_FILL;
					else st_nxt = ST_IDLE;
				end
			end
			ST_TRI: begin
				idx_nxt = idx_r + 8'h01;
				if (idx_r == `TSC_TRI_LAST) st_nxt = ST_IDLE;
			end
			ST_FILL: begin
				idx_nxt = idx_r + 8'h01;
				if (idx_r == `TSC_CM_LAST) st_nxt = ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= ST_IDLE;
			idx_r <= 8'h00;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			idx_r <= idx_nxt;
			busy_r <= (st_nxt != ST_IDLE);
		end
	end

	// Memory write ports, not reset so contents persist
	always_ff @(posedge mclk) begin
		if (cm_we_d) cm_data[cm_wa] <= cm_wd;
		if (cm_we_c) cm_code[cm_wa] <= cmd_code;
		if (st_r == ST_TRI) tri_mem[idx_r[4:0]] <= mdata_r[3:0];
		if (to_trunk) trunk_tx_buf[slot_of(up_data)] <= ubyte;
		if (slot_end) trunk_rx_buf[tif.slot] <= tbyte;
	end

	// Receive shifters, MSB first
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			up_sh_r <= 8'hFF;
			tr_sh_r <= 8'hFF;
		end else if (tif.rx_stb) begin
			up_sh_r <= ubyte;
			tr_sh_r <= tbyte;
		end
	end

	// Line drivers updated on the falling link clock edge
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sub_o_r <= 1'b0;
			sub_oe_r <= 1'b0;
			tr_o_r <= 1'b0;
			tr_oe_r <= 1'b0;
		end else if (tif.tx_stb) begin
			sub_o_r <= mode_r[`TSC_MB_OPEN_DRAIN] ? 1'b0 : dn_bit;
			sub_oe_r <= sub_en & (~mode_r[`TSC_MB_OPEN_DRAIN] | ~dn_bit);
			tr_o_r <= tr_byte[tx_bit];
			tr_oe_r <= trunk_en & ~tri_cur;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign sub_tx_o = sub_o_r;
	assign sub_tx_oe = sub_oe_r;
	assign trunk_tx_o = tr_o_r;
	assign trunk_tx_oe = tr_oe_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence s_tri_go;
		(st_r == ST_EXEC) && (mcmd_r == `TSC_CMD_WR_TRI) && !hw_we;
	endsequence

	sequence s_tri_run;
		(st_r == ST_TRI) [*8] ##24 (st_r == ST_TRI) ##1 (st_r == ST_IDLE && !busy_r);
	endsequence

	a_data_only: assert property (host_exec && !cm_reset_mode && mcmd_r == `TSC_CMD_WR_DATA
		|=> $stable(host_code) && host_rd == $past(mdata_r))
		else $error("data-only write changed code or missed data");
	a_read_back: assert property (host_exec && mcmd_r == `TSC_CMD_RD_DATA
		|=> mdata_r == $past(host_rd))
		else $error("memory read did not reach data register");
	a_code_write: assert property (host_cw |=> host_code == $past(cmd_code))
		else $error("code nibble not written");
	a_tri_fill: assert property (s_tri_go |=> s_tri_run)
		else $error("tristate fill length wrong");
	a_mode_ce: assert property (wr_mode && wd == `TSC_MODE_NORMAL_SUB
		|=> sub_en && run_mode && !trunk_en)
		else $error("mode CE not applied");
	a_mode_ee: assert property (wr_mode && wd == `TSC_MODE_NORMAL_ALL
		|=> sub_en && trunk_en)
		else $error("mode EE did not start trunk");
	a_startup_irq: assert property (startup |=> top_interrupt_status_val == `TSC_TOP_INTERRUPT_STATUS_STARTUP)
		else $error("start-up interrupt status wrong");
	a_fifo_reset: assert property (wr_fifo_rst && !(hw_we || startup) |=> !fifo_ne)
		else $error("FIFO not emptied");
	a_status_ok: assert property (rd_acc && a_off == `TSC_A_STAT && run_mode && tif.synced
		|=> hrdata_r == {24'h00_0000, `TSC_STAT_OK})
		else $error("status word wrong");
	a_irq_read: assert property (rd_acc && a_off == `TSC_A_TOP_INTERRUPT_STATUS_SW && fifo_ne
		|=> hrdata_r[6])
		else $error("switch interrupt missing");
	a_ci_push: assert property (hw_we |=> fifo_ne)
		else $error("indication change not queued");
	a_tri_hold: assert property (tif.tx_stb && tri_cur |=> !trunk_tx_oe)
		else $error("tristate slot driven");
	a_busy_cmd: assert property (wr_mcmd |=> busy_r && st_r == ST_EXEC)
		else $error("busy flag not raised");
endmodule : tsc_switch_core

/* File: verif/tsc_sub_model.sv */
// Subscriber transceiver and trunk source on the framed serial highway
`timescale 1ns/1ps
module tsc_sub_model (
	output logic link_clk,
	output logic frame_sync,
	output logic sub_rx,
	output logic trunk_rx,
	input wire logic sub_tx_o,
	input wire logic sub_tx_oe,
	input wire logic [3:0] ci_up
);
	logic [7:0] cnt;
	logic [7:0] sh;
	logic [7:0] tr_byte;
	logic [7:0] cap [0:31];
	wire logic [7:0] ci_byte;
	wire logic sub_wire;
	// Indication code in the middle bits, the rest ones
	assign ci_byte = {2'b11, ci_up, 2'b11};
	// Open-drain line with pull-up
	assign sub_wire = sub_tx_oe ? sub_tx_o : 1'b1;
	// Start just before bit 0 of slot 0
	initial begin
		link_clk = 1'b0;
		cnt = 8'hFF;
		sh = 8'h00;
		frame_sync = 1'b0;
		sub_rx = 1'b1;
		trunk_rx = 1'b1;
	end
	// Highway clock, phase unrelated to mclk
	always #62.5 link_clk = ~link_clk;
	// New bit on falling edge, MSB first; sync marks bit 0 of slot 0
	always @(negedge link_clk) begin
		cnt = cnt + 8'h01;
		tr_byte = {3'b010, cnt[7:3]};
		frame_sync = (cnt == 8'h00);
		sub_rx = (cnt[7:3] == 5'h02) ? ci_byte[3'h7 - cnt[2:0]] : 1'b1;
		trunk_rx = tr_byte[3'h7 - cnt[2:0]];
	end
	// Collect each downstream byte by slot; a bit arrives one cell after its own
	always @(posedge link_clk) begin
		sh = {sh[6:0], sub_wire};
		if (cnt[2:0] == 3'h0) begin
			cap[cnt[7:3] - 5'h01] = sh;
		end
	end
endmodule : tsc_sub_model

/* File: verif/timeslot_switch_control_memory_tb_top.sv */
// Register-level bench of the time-slot switch
`timescale 1ns/1ps
`include "tsc_defs.svh"
module timeslot_switch_control_memory_tb_top;
	logic mclk, reset_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic link_clk, frame_sync, sub_rx, trunk_rx;
	logic sub_tx_o, sub_tx_oe, trunk_tx_o, trunk_tx_oe;
	logic [3:0] ci_up;
	logic od_on, od_bad, tr_on, tr_bad;
	int miscompares, check_count;

	tsc_switch_core dut (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.link_clk(link_clk), .frame_sync(frame_sync), .sub_rx(sub_rx),
		.sub_tx_o(sub_tx_o), .sub_tx_oe(sub_tx_oe), .trunk_rx(trunk_rx),
		.trunk_tx_o(trunk_tx_o), .trunk_tx_oe(trunk_tx_oe));

	tsc_sub_model m (.link_clk(link_clk), .frame_sync(frame_sync), .sub_rx(sub_rx),
		.trunk_rx(trunk_rx), .sub_tx_o(sub_tx_o), .sub_tx_oe(sub_tx_oe), .ci_up(ci_up));

	// System clock
	always #4 mclk = ~mclk;

	// Watch pins that must stay quiet
	always @(posedge mclk) begin
		if (od_on && sub_tx_o !== 1'b0) begin
			od_bad <= 1'b1;
		end
		if (tr_on && trunk_tx_oe !== 1'b0) begin
			tr_bad <= 1'b1;
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One single AHB-Lite word transfer; read data left in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		hsize <= 3'b010;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		rd = hrdata;
	endtask : bus

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(nm, {24'h000000, e}, rd);
	endtask : rdchk

	// Poll the access-busy flag until it drops
	task automatic idle_wait;
		for (int n = 0; n < 500; n++) begin
			bus(1'b0, `TSC_A_STAT_SW, 8'h00);
			if (rd[4] === 1'b0) break;
		end
		chk("busy_end", 32'h00000000, {31'h0, rd[4]});
	endtask : idle_wait

	// Control memory access: address, data, command
	task automatic cm(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
		bus(1'b1, `TSC_A_MADDR, a);
		bus(1'b1, `TSC_A_MDATA, d);
		bus(1'b1, `TSC_A_MCMD, c);
		idle_wait();
	endtask : cm

	task automatic frames(input int n);
		repeat (n) @(posedge frame_sync);
		@(posedge mclk);
	endtask : frames

	task automatic do_reset;
		reset_n <= 1'b0;
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
	endtask : do_reset

	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	// Hang guard, about 13 frames of tests plus margin
	initial begin
		#600000;
		miscompares++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		{mclk, reset_n, hsel, hwrite, hwdata, haddr, htrans} = '0;
		{od_on, od_bad, tr_on, tr_bad} = '0;
		hsize = 3'b010;
		ci_up = 4'hF;
		miscompares = 0;
		check_count = 0;
		@(posedge mclk);
		do_reset();
		frames(2);
		rdchk("mode_rst", `TSC_A_MODE, 8'h00);
		chk("hresp", 32'h0, {31'h0, hresp});
		bus(1'b1, 8'h2C, 8'h5A);
		rdchk("unmapped", 8'h2C, 8'h00);
		// Memory reset mode fill
		bus(1'b1, `TSC_A_MDATA, 8'hFF);
		bus(1'b1, `TSC_A_MCMD, 8'h70);
		bus(1'b0, `TSC_A_STAT_SW, 8'h00);
		chk("busy_fill", 32'h00000010, rd);
		idle_wait();
		bus(1'b1, `TSC_A_MODE, 8'h80);
		cm(8'h08, 8'h00, 8'hC8);
		rdchk("fill_read", `TSC_A_MDATA, 8'hFF);
		// Slot pairs and switching paths
		cm(8'h88, 8'hFF, 8'h78);
		cm(8'h89, 8'hFF, 8'h70);
		cm(8'h08, 8'hC3, 8'h7A);
		cm(8'h09, 8'hC3, 8'h7B);
		cm(8'h00, 8'h08, 8'h71);
		cm(8'h80, 8'h81, 8'h71);
		bus(1'b1, `TSC_A_MODE, 8'hCE);
		// Driver refreshes only on a link clock edge
		repeat (20) @(posedge mclk);
		od_on <= 1'b1;
		rdchk("top_interrupt_status_start", `TSC_A_TOP_INTERRUPT_STATUS, 8'h48);
		bus(1'b1, `TSC_A_CMD, 8'h10);
		rdchk("fifo_clear", `TSC_A_TOP_INTERRUPT_STATUS_SW, 8'h00);
		rdchk("status", `TSC_A_STAT, 8'h25);
		// Tristate fill, then trunk on
		bus(1'b1, `TSC_A_MDATA, 8'hF0);
		bus(1'b1, `TSC_A_MCMD, 8'h68);
		idle_wait();
		bus(1'b1, `TSC_A_MODE, 8'hEE);
		tr_on <= 1'b1;
		rdchk("mode_ee", `TSC_A_MODE, 8'hEE);
		rdchk("status_ee", `TSC_A_STAT, 8'h25);
		frames(3);
		chk("trunk_oe", 32'h0, {31'h0, tr_bad});
		chk("down_ci", 32'h000000C3, {24'h0, m.cap[2]});
		chk("down_sw", 32'h00000042, {24'h0, m.cap[0]});
		// Data-only write keeps the slot code
		cm(8'h08, 8'hF3, 8'h48);
		frames(2);
		chk("down_f3", 32'h000000F3, {24'h0, m.cap[2]});
		bus(1'b1, `TSC_A_ARB_EN, 8'h01);
		frames(2);
		chk("arb_avail", 32'h000000E3, {24'h0, m.cap[2]});
		// Three indication changes on slot 2
		ci_up <= 4'hC;
		frames(1);
		ci_up <= 4'hF;
		frames(1);
		ci_up <= 4'hC;
		frames(2);
		rdchk("top_interrupt_status_sw", `TSC_A_TOP_INTERRUPT_STATUS_SW, 8'h40);
		for (int i = 0; i < 3; i++) begin
			rdchk("fifo_entry", `TSC_A_INDICATION_CHANGE_FIFO, 8'h88);
		end
		rdchk("top_interrupt_status_sw_end", `TSC_A_TOP_INTERRUPT_STATUS_SW, 8'h00);
		cm(8'h88, 8'h00, 8'hC8);
		rdchk("up_read", `TSC_A_MDATA, 8'hF3);
		chk("sub_od", 32'h0, {31'h0, od_bad});
		// Memory survives a second reset
		od_on <= 1'b0;
		tr_on <= 1'b0;
		do_reset();
		cm(8'h88, 8'h00, 8'hC8);
		rdchk("keep_read", `TSC_A_MDATA, 8'hF3);
		report_and_stop();
	end
endmodule : timeslot_switch_control_memory_tb_top
